/* bench/mrcs_top_assertions.sv */
// Purpose: Port checks for the reset and calibration block.
// Assumes: One clock; i_rst asynchronous, active high.
// Notes:   Bound into every mrcs_top at the foot of this file.
module mrcs_top_chk #(
    parameter int unsigned N_IF        = 1,
    parameter int unsigned CAL_TMO_CYC = 50
) (
    // Clock, reset and stimulus
    input wire logic            i_mclk,
    input wire logic            i_rst,
    input wire logic            i_col_rst_n,
    input wire logic            i_usr_rst_req,
    input wire logic            i_cal_end,
    input wire logic            i_cal_ok,
    input wire logic            i_psel,
    input wire logic            i_penable,
    // Outputs under watch
    input wire logic            o_cal_start,
    input wire logic            o_reset_done,
    input wire logic            o_cal_pass,
    input wire logic            o_cal_fail,
    input wire logic [N_IF-1:0] o_phy_rst_n,
    input wire logic            o_pready
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cal_cyc;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Cycles spent calibrating; a stuck engine must not hang us
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cal_cyc <= 0;
        end else begin
            cal_cyc <= o_cal_start ? cal_cyc + 1 : 0;
        end
    end

    // ==========================================================
    // Reset intake and status
    chk_col_reset: assert property (!i_col_rst_n |->
        o_phy_rst_n == '0 && !o_reset_done) else $error("col reset lost");
    chk_phy_fanout: assert property (o_phy_rst_n == '0 ||
        o_phy_rst_n == '1) else $error("phy resets disagree");
    chk_sync_release: assert property ($rose(o_phy_rst_n[0]) |->
        $past(i_col_rst_n, 3)) else $error("phy reset released early");
    chk_req_taken: assert property (o_reset_done &&
        $rose(i_usr_rst_req) ##1 i_usr_rst_req |-> ##[1:6] !o_reset_done)
        else $error("request not taken");
    chk_done_in_reset: assert property ((o_phy_rst_n != '1) |->
        !o_reset_done) else $error("done high in reset");
    chk_done_cause: assert property ($rose(o_reset_done) |->
        $past(o_cal_start)) else $error("done without calibration");
    chk_cal_result: assert property (o_cal_start && i_cal_end |=>
        o_reset_done && o_cal_pass == $past(i_cal_ok) &&
        o_cal_fail != $past(i_cal_ok)) else $error("wrong cal flags");
    chk_cal_bound: assert property (cal_cyc <= CAL_TMO_CYC + 1)
        else $error("calibration never times out");
    chk_flag_excl: assert property (!(o_cal_pass && o_cal_fail))
        else $error("pass and fail together");
    chk_flag_idle: assert property (!o_reset_done |->
        !o_cal_pass && !o_cal_fail) else $error("flag while busy");
    chk_apb_wait: assert property (i_psel && i_penable && !o_pready
        |=> o_pready) else $error("no answer after one wait");

    cover property (o_cal_start && i_cal_end && !i_cal_ok);
    cover property ($fell(o_reset_done) && i_col_rst_n);
    cover property (cal_cyc == CAL_TMO_CYC);
endmodule : mrcs_top_chk

bind mrcs_top mrcs_top_chk #(.N_IF(N_IF), .CAL_TMO_CYC(CAL_TMO_CYC))
    i_mrcs_top_chk (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_col_rst_n(i_col_rst_n), .i_usr_rst_req(i_usr_rst_req),
    .i_cal_end(i_cal_end), .i_cal_ok(i_cal_ok), .i_psel(i_psel),
    .i_penable(i_penable), .o_cal_start(o_cal_start),
    .o_reset_done(o_reset_done), .o_cal_pass(o_cal_pass),
    .o_cal_fail(o_cal_fail), .o_phy_rst_n(o_phy_rst_n),
    .o_pready(o_pready));

/* bench/mrcs_top_test.sv */
// Purpose: Self-checking bench for the reset and calibration block.
// Assumes: 100 MHz clock; package hold count, short timeout count.
// Notes:   Expected results are queued and checked by a monitor.
module mrcs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned NIF = 2;
    logic           i_mclk, i_rst, i_col_rst_n, go, good, req, done_q;
    logic           i_psel, i_penable, i_pwrite, cal_end, cal_ok, irq;
    logic           cal_start, done, pass, fail, pready, pslverr;
    logic [11:0]    i_paddr;
    logic [31:0]    i_pwdata, prdata, rng;
    logic [3:0]     width;
    logic [7:0]     lat;
    logic [NIF-1:0] phy_n;
    logic [32:0]    exp_rd[$];
    logic [1:0]     exp_cal[$];
    int             failures, n_compared, cyc;

    mrcs_top #(.N_IF(NIF), .CAL_TMO_CYC(50), .HOLD_CYC(10)) i_mrcs_top (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_col_rst_n(i_col_rst_n),
        .i_usr_rst_req(req), .i_cal_end(cal_end), .i_cal_ok(cal_ok),
        .o_cal_start(cal_start), .o_reset_done(done), .o_cal_pass(pass),
        .o_cal_fail(fail), .o_phy_rst_n(phy_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_irq(irq));
    mrcs_user_model i_mrcs_user_model (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_cal_start(cal_start), .i_cal_lat(lat), .i_cal_good(good),
        .i_go(go), .i_width(width), .o_cal_end(cal_end),
        .o_cal_ok(cal_ok), .o_req(req));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input string nm, input logic [32:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // APB transfer; held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] exp);
        exp_rd.push_back(exp);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        // Idle edge: a following call never drives psel twice at once
        @(posedge i_mclk);
    endtask : apb

    // Bounded wait for the block to come out of reset
    task automatic wait_done;
        int k;
        k = 0;
        repeat (8) @(posedge i_mclk);
        while (done !== 1'b1 && k < 400) begin
            @(posedge i_mclk);
            k++;
        end
        if (k == 400) check("done wait", 33'h0, 33'h1);
        @(posedge i_mclk);
    endtask : wait_done

    // User request pulse; again repeats it while busy
    task automatic request(input logic [3:0] w, input logic [7:0] l,
                           input logic g, input logic again);
        lat   <= l;
        good  <= g;
        width <= w;
        go    <= 1'b1;
        exp_cal.push_back({g, !g});
        @(posedge i_mclk);
        go <= 1'b0;
        repeat (8) @(posedge i_mclk);
        go <= again;
        @(posedge i_mclk);
        go <= 1'b0;
        wait_done();
    endtask : request

    // ==========================================================
    // Monitor: pairs each result with the oldest expectation
    always @(posedge i_mclk) begin
        done_q <= done;
        if (i_psel && i_penable && pready === 1'b1)
            check("apb", {pslverr, i_pwrite ? 32'h0 : prdata},
                  exp_rd.pop_front());
        if (done === 1'b1 && done_q === 1'b0)
            check("cal", {31'h0, pass, fail},
                  {31'h0, exp_cal.pop_front()});
    end

    // Clock and hang guard
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {i_rst, i_col_rst_n, good, width, lat} = {3'b111, 4'h2, 8'h05};
        {go, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {failures, n_compared, cyc, rng} = {32'h0, 32'h0, 32'h0, 32'h5915};
        exp_cal.push_back(2'b10);
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        wait_done();
        check("phy", {31'h0, phy_n}, 33'h3);
        apb(1'b0, mrcs_pkg::OFS_STATUS, 32'h0, 33'h3);
        rng = xs(rng);
        apb(1'b1, mrcs_pkg::OFS_INT_MASK, rng, 33'h0);
        apb(1'b0, mrcs_pkg::OFS_INT_MASK, 32'h0, {1'b0, rng & 32'h7});
        apb(1'b1, mrcs_pkg::OFS_INT_MASK, 32'h7, 33'h0);
        repeat (2) @(posedge i_mclk);
        check("irq set", {32'h0, irq}, 33'h1);
        apb(1'b0, mrcs_pkg::OFS_INT_STAT, 32'h0, 33'h2);
        apb(1'b0, mrcs_pkg::OFS_INT_STAT, 32'h0, 33'h0);
        repeat (2) @(posedge i_mclk);
        check("irq clear", {32'h0, irq}, 33'h0);
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        request(4'h2, 8'h03, 1'b0, 1'b1);
        apb(1'b0, mrcs_pkg::OFS_STATUS, 32'h0, 33'h5);
        apb(1'b0, mrcs_pkg::OFS_INT_STAT, 32'h0, 33'h5);
        rng = xs(rng);
        request(4'h2 + {2'h0, rng[1:0]}, 8'hFF, 1'b0, 1'b0);
        lat  <= 8'h05;
        good <= 1'b1;
        exp_cal.push_back(2'b10);
        apb(1'b1, mrcs_pkg::OFS_CTRL, 32'h1, 33'h0);
        wait_done();
        exp_cal.push_back(2'b10);
        i_col_rst_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        check("col phy", {30'h0, phy_n, done}, 33'h0);
        i_col_rst_n <= 1'b1;
        wait_done();
        wrap_up();
    end
endmodule : mrcs_top_test

/* bench/mrcs_user_model.sv */
// Purpose: User logic and calibration engine beside the block.
// Assumes: Same clock as the block.
// Notes:   Latency 8'hFF answers only after 256 cycles, so the 50-cycle timeout wins.
module mrcs_user_model (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Calibration engine
    input  wire logic       i_cal_start,
    input  wire logic [7:0] i_cal_lat,
    input  wire logic       i_cal_good,
    // Request pulse control
    input  wire logic       i_go,
    input  wire logic [3:0] i_width,
    // Engine answer and request pin
    output logic            o_cal_end,
    output logic            o_cal_ok,
    output logic            o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cyc_reg;
    logic [3:0] wid_reg;

    // ==========================================================
    // Engine answers after a set latency; the result line toggles
    // outside answers so a stale value is never mistaken for one
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cyc_reg   <= 8'h00;
            o_cal_end <= 1'b0;
            o_cal_ok  <= 1'b0;
        end else begin
            o_cal_end <= i_cal_start && !o_cal_end && cyc_reg == i_cal_lat;
            cyc_reg   <= (i_cal_start && !o_cal_end) ?
                         cyc_reg + 8'h01 : 8'h00;
            o_cal_ok  <= (i_cal_start && cyc_reg == i_cal_lat) ?
                         i_cal_good : ~o_cal_ok;
        end
    end

    // ==========================================================
    // Request pulse, high for i_width cycles, then low
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wid_reg <= 4'h0;
        end else begin
            wid_reg <= i_go ? i_width :
                       (wid_reg != 4'h0 ? wid_reg - 4'h1 : 4'h0);
        end
    end
    assign o_req = (wid_reg != 4'h0);
endmodule : mrcs_user_model

/* hdl/mrcs_pkg.sv */
// Purpose: Constants and types for the memory reset and
//          calibration status block.
// Assumes: One 100 MHz core clock, also used by the PHY side.
// Notes:   Register offsets are byte addresses on APB.
package mrcs_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned RST_HOLD_NS  = 100;
    // Least time, so round up
    localparam int unsigned RST_HOLD_CYC =
        (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CAL_TMO_US   = 1000;
    // Longest time, so round down
    localparam int unsigned CAL_TMO_CYC  = CAL_TMO_US * CLK_MHZ;
    localparam int unsigned REQ_MIN_CYC  = 2;

    // ==========================================================
    // Register map
    localparam int unsigned ADDR_W       = 12;
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_STATUS   = 12'h004;
    localparam logic [11:0] OFS_INT_STAT = 12'h008;
    localparam logic [11:0] OFS_INT_MASK = 12'h00C;

    // Field positions
    localparam int unsigned CTRL_SWREQ   = 0;
    localparam int unsigned ST_DONE      = 0;
    localparam int unsigned ST_PASS      = 1;
    localparam int unsigned ST_FAIL      = 2;
    localparam int unsigned ST_BUSY      = 3;
    localparam int unsigned EV_REQ       = 0;
    localparam int unsigned EV_PASS      = 1;
    localparam int unsigned EV_FAIL      = 2;
    localparam int unsigned EV_W         = 3;

    // Reset values
    localparam logic [2:0]  INT_MASK_RST = 3'h0;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        MRCS_RESET,
        MRCS_CAL,
        MRCS_READY
    } mrcs_state_t;

endpackage : mrcs_pkg

/* hdl/mrcs_top.sv */
// Purpose: Reset intake, reset sequencing and calibration
//          status for an external memory interface.
// Assumes: PHY calibration engine runs on i_mclk; request
//          pin and column reset are asynchronous.
// Notes:   Registers sit on an APB slave with one wait state.

// ==============================================================
// Reset synchroniser: asserts at once, releases on the clock
module mrcs_rst_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst,
    // Synchronised reset
    output logic      o_rst_n
);

    logic meta_reg;

    // Two stages keep a metastable release off the PHY domain
    always_ff @(posedge i_clk or posedge i_arst) begin
        if (i_arst) begin
            meta_reg <= 1'b0;
            o_rst_n  <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            o_rst_n  <= meta_reg;
        end
    end

endmodule : mrcs_rst_sync

// ==============================================================
// Top level
module mrcs_top #(
    parameter int unsigned N_IF        = 1,
    parameter int unsigned CAL_TMO_CYC = mrcs_pkg::CAL_TMO_CYC,
    parameter int unsigned HOLD_CYC    = mrcs_pkg::RST_HOLD_CYC
) (
    // Clock and reset
    input  wire logic            i_mclk,
    input  wire logic            i_rst,
    // Reset sources
    input  wire logic            i_col_rst_n,
    input  wire logic            i_usr_rst_req,
    // Calibration engine
    input  wire logic            i_cal_end,
    input  wire logic            i_cal_ok,
    output logic                 o_cal_start,
    // Status to user logic
    output logic                 o_reset_done,
    output logic                 o_cal_pass,
    output logic                 o_cal_fail,
    output logic [N_IF-1:0]      o_phy_rst_n,
    // APB slave
    input  wire logic            i_psel,
    input  wire logic            i_penable,
    input  wire logic            i_pwrite,
    input  wire logic [11:0]     i_paddr,
    input  wire logic [31:0]     i_pwdata,
    output logic [31:0]          o_prdata,
    output logic                 o_pready,
    output logic                 o_pslverr,
    // Interrupt
    output logic                 o_irq
);

    // ==========================================================
    // Declarations
    localparam logic [31:0] TMO_LAST  = 32'(CAL_TMO_CYC - 1);
    localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYC - 1);
    localparam logic [1:0]  REQ_MIN   =
        2'(mrcs_pkg::REQ_MIN_CYC);

    logic                  col_arst;
    logic                  seq_rst_n;
    logic                  seq_rst;
    logic                  phy_arst;
    logic                  phy_up;
    mrcs_pkg::mrcs_state_t state_reg;
    mrcs_pkg::mrcs_state_t state_next;
    logic [31:0]           tmr_reg;
    logic [31:0]           tmr_next;
    logic                  hold_reg;
    logic                  req_meta_reg;
    logic                  req_sync_reg;
    logic [1:0]            req_cnt_reg;
    logic                  usr_req_reg;
    logic                  sw_req_reg;
    logic                  req_take;
    logic                  cal_done_ok;
    logic                  cal_done_bad;
    logic [2:0]            ev_vec;
    logic [2:0]            int_stat_reg;
    logic [2:0]            int_stat_next;
    logic [2:0]            int_mask_reg;
    logic [2:0]            int_clr;
    logic                  xfer_done;
    logic                  addr_hit;
    logic [31:0]           rdata_mux;

    // ==========================================================
    // Reset sources
    // Column reset is async and clears the sequencer at once;
    // its release is synchronised so no flop sees a late edge
    assign col_arst = i_rst | ~i_col_rst_n;

    mrcs_rst_sync u_seq_sync (
        .i_clk   (i_mclk),
        .i_arst  (col_arst),
        .o_rst_n (seq_rst_n)
    );

    assign seq_rst  = ~seq_rst_n;
    assign phy_arst = seq_rst | hold_reg;
    // Every PHY reset released
    assign phy_up   = &o_phy_rst_n;

    // ==========================================================
    // User reset request intake
    // Two stages, then a width count on the clean copy only
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
        end else begin
            req_meta_reg <= i_usr_rst_req;
            req_sync_reg <= req_meta_reg;
        end
    end

    // Saturating high count; at most one pulse out per request pulse
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            req_cnt_reg <= 2'h0;
            usr_req_reg <= 1'b0;
        end else begin
            usr_req_reg <= 1'b0;
            if (!req_sync_reg) begin
                req_cnt_reg <= 2'h0;
            end else if (req_cnt_reg != REQ_MIN) begin
                req_cnt_reg <= req_cnt_reg + 2'h1;
                // Fires on the second high sample
                usr_req_reg <= (req_cnt_reg == REQ_MIN - 2'h1);
            end
        end
    end

    // A request is only taken once the last one is finished
    assign req_take = (usr_req_reg | sw_req_reg) &
                      (state_reg == mrcs_pkg::MRCS_READY);

    // ==========================================================
    // Sequencer
    // Results wait for the PHY to leave reset, so done can never
    // rise while a PHY reset is still held
    assign cal_done_ok  = (state_reg == mrcs_pkg::MRCS_CAL) & phy_up &
                          i_cal_end & i_cal_ok;
    // A timeout counts as a failed calibration
    assign cal_done_bad = (state_reg == mrcs_pkg::MRCS_CAL) & phy_up &
                          ((i_cal_end & ~i_cal_ok) |
                           (~i_cal_end & (tmr_reg == TMO_LAST)));

    // Next state
    always_comb begin
        state_next = state_reg;
        tmr_next   = tmr_reg + 32'h1;
        case (state_reg)
            mrcs_pkg::MRCS_RESET: begin
                if (tmr_reg == HOLD_LAST) begin
                    state_next = mrcs_pkg::MRCS_CAL;
                    tmr_next   = 32'h0;
                end
            end
            mrcs_pkg::MRCS_CAL: begin
                if (cal_done_ok || cal_done_bad) begin
                    state_next = mrcs_pkg::MRCS_READY;
                    tmr_next   = 32'h0;
                end
            end
            mrcs_pkg::MRCS_READY: begin
                tmr_next = 32'h0;
                if (req_take) begin
                    state_next = mrcs_pkg::MRCS_RESET;
                end
            end
            default: begin
                state_next = mrcs_pkg::MRCS_RESET;
                tmr_next   = 32'h0;
            end
        endcase
    end

    // State and timer
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            state_reg <= mrcs_pkg::MRCS_RESET;
            tmr_reg   <= 32'h0;
        end else begin
            state_reg <= state_next;
            tmr_reg   <= tmr_next;
        end
    end

    // Holds the PHY in reset across the whole reset state
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            hold_reg <= 1'b1;
        end else begin
            hold_reg <= (state_next == mrcs_pkg::MRCS_RESET);
        end
    end

    // Calibration start stays high while calibrating
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            o_cal_start <= 1'b0;
        end else begin
            o_cal_start <= (state_next == mrcs_pkg::MRCS_CAL);
        end
    end

    // ==========================================================
    // Status outputs
    // Done is low during reset and calibration alike
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            o_reset_done <= 1'b0;
        end else begin
            o_reset_done <=
                (state_next == mrcs_pkg::MRCS_READY);
        end
    end

    // Exactly one flag is set on each completion
    always_ff @(posedge i_mclk or posedge seq_rst) begin
        if (seq_rst) begin
            o_cal_pass <= 1'b0;
            o_cal_fail <= 1'b0;
        end else if (state_next != mrcs_pkg::MRCS_READY) begin
            o_cal_pass <= 1'b0;
            o_cal_fail <= 1'b0;
        end else if (cal_done_ok || cal_done_bad) begin
            o_cal_pass <= cal_done_ok;
            o_cal_fail <= cal_done_bad;
        end
    end

    // ==========================================================
    // PHY-side resets, one per interface in the column
    genvar gi;
    generate
        for (gi = 0; gi < N_IF; gi++) begin : g_if
            mrcs_rst_sync u_sync (
                .i_clk   (i_mclk),
                .i_arst  (phy_arst),
                .o_rst_n (o_phy_rst_n[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Interrupt status
    assign ev_vec[mrcs_pkg::EV_REQ]  = req_take;
    assign ev_vec[mrcs_pkg::EV_PASS] = cal_done_ok;
    assign ev_vec[mrcs_pkg::EV_FAIL] = cal_done_bad;

    // Clears only the bits that the read returned
    assign int_clr = (xfer_done && !i_pwrite &&
                      i_paddr == mrcs_pkg::OFS_INT_STAT) ?
                     o_prdata[2:0] : 3'h0;

    // Set wins over a clear in the same cycle
    assign int_stat_next = (int_stat_reg & ~int_clr) | ev_vec;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            int_stat_reg <= 3'h0;
        end else begin
            int_stat_reg <= int_stat_next;
        end
    end

    // Registered so the output comes from a flop
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_stat_next & int_mask_reg);
        end
    end

    // ==========================================================
    // APB slave
    // One wait state lets read data come from a flop
    assign xfer_done = i_psel & i_penable & o_pready;

    always_comb begin
        addr_hit  = 1'b1;
        rdata_mux = mrcs_pkg::RDATA_ZERO;
        case (i_paddr)
            mrcs_pkg::OFS_CTRL: begin
                rdata_mux = mrcs_pkg::RDATA_ZERO;
            end
            mrcs_pkg::OFS_STATUS: begin
                rdata_mux[mrcs_pkg::ST_DONE] = o_reset_done;
                rdata_mux[mrcs_pkg::ST_PASS] = o_cal_pass;
                rdata_mux[mrcs_pkg::ST_FAIL] = o_cal_fail;
                rdata_mux[mrcs_pkg::ST_BUSY] = ~o_reset_done;
            end
            mrcs_pkg::OFS_INT_STAT: begin
                rdata_mux[2:0] = int_stat_reg;
            end
            mrcs_pkg::OFS_INT_MASK: begin
                rdata_mux[2:0] = int_mask_reg;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Ready, read data and error
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= mrcs_pkg::RDATA_ZERO;
            o_pslverr <= 1'b0;
        end else if (i_psel && i_penable && !o_pready) begin
            o_pready  <= 1'b1;
            o_prdata  <= i_pwrite ? mrcs_pkg::RDATA_ZERO
                                  : rdata_mux;
            o_pslverr <= ~addr_hit;
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Mask register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            int_mask_reg <= mrcs_pkg::INT_MASK_RST;
        end else if (xfer_done && i_pwrite &&
                     i_paddr == mrcs_pkg::OFS_INT_MASK) begin
            int_mask_reg <= i_pwdata[2:0];
        end
    end

    // Software reset request, a one-cycle pulse
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sw_req_reg <= 1'b0;
        end else begin
            sw_req_reg <= xfer_done && i_pwrite &&
                          i_paddr == mrcs_pkg::OFS_CTRL &&
                          i_pwdata[mrcs_pkg::CTRL_SWREQ];
        end
    end

endmodule : mrcs_top
